// ===== hw/hsp_top.sv
// hub sideband pin control: interrupt pin, fault sense, port power, stages
//
// Behaviour
// - general mode: enabled status set pulls interrupt low
// - interrupt stays low until status is cleared or masked
// - suspend mode: pin low unless configured and active
// - low fault sense input means fault reported
// - power output high requests power, low removes
// - capture reference selects once during init stage
// - reset low holds block reset in standby
// - connect high moves configuration into communication
// - connect low: wait for connect bit clear
// - connect high: enter communication without waiting
// - connect rising edge moves into communication
// - status bits latch on new events only
// - mask selects which status bits drive interrupt
// - interrupt pin sampled at init picks table
`default_nettype none
module hsp_top
	import hsp_pkg::*;
#(
	parameter int INIT_CYC = HSP_INIT_CYC
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	output var  logic        irq,
	input  wire logic        hub_connect,
	input  wire logic        overcurrent_sense_low,
	input  wire logic [1:0]  ref_sel,
	input  wire logic        int_pin_in,
	output var  logic        int_pin_out,
	output var  logic        int_pin_oe,
	output var  logic        port_power_enable,
	output var  logic [15:0] ref_freq_khz,
	output var  logic        standby
);
	localparam int CW = $clog2(INIT_CYC + 1);

	////////////////////////////////////////////////////////////////////////
	// input synchronisers
	logic [2:0] pins_s;
	logic [1:0] refsel_s;
	logic       conn_s;
	logic       fault_s;
	logic       intin_s;

	hsp_sync #(.W(3)) u_sync_pins (
		.clk   (pclk),
		.rst_n (presetn),
		.d     ({int_pin_in, ~overcurrent_sense_low, hub_connect}),
		.q     (pins_s)
	);
	hsp_sync #(.W(2)) u_sync_ref (
		.clk   (pclk),
		.rst_n (presetn),
		.d     (ref_sel),
		.q     (refsel_s)
	);
	assign conn_s  = pins_s[0];
	assign fault_s = pins_s[1];
	assign intin_s = pins_s[2];

	////////////////////////////////////////////////////////////////////////
	// status and mask
	hsp_evt_if #(.N(HSP_EVT_NUM)) evt_if ();

	hsp_irq #(.N(HSP_EVT_NUM)) u_irq (
		.pclk    (pclk),
		.presetn (presetn),
		.e       (evt_if.irq)
	);

	////////////////////////////////////////////////////////////////////////
	// stage machine, edge memories and captured straps
	hsp_stage_t  stage_r;
	hsp_stage_t  stage_nxt;
	logic [CW-1:0] cnt_r;
	logic [CW-1:0] cnt_nxt;
	logic        conn_d_r;
	logic        conn_d_nxt;
	logic        fault_d_r;
	logic        fault_d_nxt;
	logic        conn_rise_r;
	logic        conn_rise_nxt;
	logic [1:0]  refsel_r;
	logic [1:0]  refsel_nxt;
	logic        second_r;
	logic        second_nxt;
	logic        standby_r;
	logic [4:0]  ctrl_r;
	logic [4:0]  ctrl_nxt;
	logic        wr_en;
	logic        rd_en;

	always_comb begin
		stage_nxt     = stage_r;
		cnt_nxt       = cnt_r;
		refsel_nxt    = refsel_r;
		second_nxt    = second_r;
		conn_d_nxt    = conn_s;
		fault_d_nxt   = fault_s;
		// remembers a rise seen during init, acted on in configuration
		conn_rise_nxt = conn_rise_r | (conn_s & ~conn_d_r);
		case (stage_r)
			HSP_STG_INIT: begin
				// straps sampled at the end of init, after synchronisers settle
				if (cnt_r == CW'(INIT_CYC - 1)) begin
					refsel_nxt = refsel_s;
					second_nxt = ~intin_s;
					stage_nxt  = HSP_STG_CONFIG;
				end else begin
					cnt_nxt = cnt_r + CW'(1);
				end
			end
			HSP_STG_CONFIG: begin
				if (conn_s) begin
					stage_nxt = HSP_STG_COMM;
				end else if (conn_rise_r) begin
					stage_nxt = HSP_STG_COMM;
				end else if (!ctrl_r[HSP_CTRL_CONNECT_N]) begin
					stage_nxt = HSP_STG_COMM;
				end
			end
			HSP_STG_COMM: begin
				stage_nxt     = HSP_STG_COMM;
				conn_rise_nxt = 1'b0;
			end
			default: begin
				stage_nxt = HSP_STG_INIT;
			end
		endcase
	end

	// reset is the standby hold; nothing is retained across it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stage_r     <= HSP_STG_INIT;
			cnt_r       <= '0;
			conn_d_r    <= 1'b0;
			fault_d_r   <= 1'b0;
			conn_rise_r <= 1'b0;
			refsel_r    <= 2'h0;
			second_r    <= 1'b0;
			standby_r   <= 1'b1;
		end else begin
			stage_r     <= stage_nxt;
			cnt_r       <= cnt_nxt;
			conn_d_r    <= conn_d_nxt;
			fault_d_r   <= fault_d_nxt;
			conn_rise_r <= conn_rise_nxt;
			refsel_r    <= refsel_nxt;
			second_r    <= second_nxt;
			standby_r   <= 1'b0;
		end
	end

	// events are edges, so a held cause never re-fires
	always_comb begin
		evt_if.evt = '0;
		evt_if.evt[HSP_EVT_FAULT]     = fault_s & ~fault_d_r;
		evt_if.evt[HSP_EVT_CONN_RISE] = conn_s & ~conn_d_r;
		evt_if.evt[HSP_EVT_COMM]      = (stage_r == HSP_STG_CONFIG)
			&& (stage_nxt == HSP_STG_COMM);
	end

	////////////////////////////////////////////////////////////////////////
	// apb slave: one wait state so read data comes from a flop
	logic [31:0] prdata_r;
	logic [31:0] prdata_nxt;
	logic        pready_r;
	logic        pready_nxt;
	logic        pslverr_r;
	logic        pslverr_nxt;
	logic        mapped;

	assign wr_en = psel & penable & pready_r & pwrite & ~pslverr_r;
	assign rd_en = psel & penable & ~pready_r;

	always_comb begin
		mapped = (paddr == HSP_OFS_CTRL) || (paddr == HSP_OFS_STATUS)
			|| (paddr == HSP_OFS_MASK) || (paddr == HSP_OFS_STATE)
			|| (paddr == HSP_OFS_FREQ);
		pready_nxt  = rd_en;
		pslverr_nxt = rd_en & ~mapped;
		prdata_nxt  = '0;
		if (rd_en && !pwrite) begin
			case (paddr)
				HSP_OFS_CTRL:   prdata_nxt[4:0] = ctrl_r;
				HSP_OFS_STATUS: prdata_nxt[HSP_EVT_NUM-1:0] = evt_if.status;
				HSP_OFS_MASK:   prdata_nxt[HSP_EVT_NUM-1:0] = evt_if.mask;
				HSP_OFS_STATE: begin
					prdata_nxt[HSP_ST_FAULT]   = fault_s;
					prdata_nxt[HSP_ST_CONNECT] = conn_s;
					prdata_nxt[HSP_ST_STAGE +: 2] = stage_r;
					prdata_nxt[HSP_ST_REFSEL +: 2] = refsel_r;
					prdata_nxt[HSP_ST_SECOND]  = second_r;
					prdata_nxt[HSP_ST_STANDBY] = standby_r;
				end
				HSP_OFS_FREQ:   prdata_nxt[15:0] = ref_freq_khz;
				default:        prdata_nxt = '0;
			endcase
		end
		ctrl_nxt = ctrl_r;
		if (wr_en && paddr == HSP_OFS_CTRL) begin
			ctrl_nxt = pwdata[4:0];
		end
		evt_if.clr_stb    = wr_en && (paddr == HSP_OFS_STATUS);
		evt_if.clr_data   = pwdata[HSP_EVT_NUM-1:0];
		evt_if.mask_stb   = wr_en && (paddr == HSP_OFS_MASK);
		evt_if.mask_wdata = pwdata[HSP_EVT_NUM-1:0];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r  <= '0;
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			ctrl_r    <= HSP_CTRL_RST;
		end else begin
			prdata_r  <= prdata_nxt;
			pready_r  <= pready_nxt;
			pslverr_r <= pslverr_nxt;
			ctrl_r    <= ctrl_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pins
	logic        int_oe_r;
	logic        int_oe_nxt;
	logic        irq_r;
	logic        pwr_r;
	logic        pwr_nxt;
	logic [15:0] freq_r;
	logic [15:0] freq_nxt;
	logic        hub_active;

	always_comb begin
		hub_active = ctrl_r[HSP_CTRL_CONFIGURED] & ~ctrl_r[HSP_CTRL_SUSPENDED];
		if (stage_r == HSP_STG_INIT) begin
			// released during init so the pin strap can be read
			int_oe_nxt = 1'b0;
		end else if (ctrl_r[HSP_CTRL_SUSP_SEL]) begin
			int_oe_nxt = ~hub_active;
		end else begin
			int_oe_nxt = evt_if.pend;
		end
		pwr_nxt  = ctrl_r[HSP_CTRL_PWR];
		// nothing shown before capture, so the value never moves once set
		if (stage_r == HSP_STG_INIT) begin
			freq_nxt = '0;
		end else begin
			freq_nxt = second_r ? HSP_FREQ_SEC[refsel_r] : HSP_FREQ_PRI[refsel_r];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_oe_r <= 1'b0;
			irq_r    <= 1'b0;
			pwr_r    <= 1'b0;
			freq_r   <= '0;
		end else begin
			int_oe_r <= int_oe_nxt;
			irq_r    <= evt_if.pend;
			pwr_r    <= pwr_nxt;
			freq_r   <= freq_nxt;
		end
	end

	assign prdata            = prdata_r;
	assign pready            = pready_r;
	assign pslverr           = pslverr_r;
	assign irq               = irq_r;
	assign int_pin_out       = 1'b0; // open drain: only ever pulls low
	assign int_pin_oe        = int_oe_r;
	assign port_power_enable = pwr_r;
	assign ref_freq_khz      = freq_r;
	assign standby           = standby_r;
endmodule // hsp_top
`default_nettype wire

// ===== hw/hsp_pkg.sv
// constants shared by the hub sideband pin control block
`default_nettype none
package hsp_pkg;
	// register byte offsets
	localparam logic [7:0] HSP_OFS_CTRL   = 8'h00;
	localparam logic [7:0] HSP_OFS_STATUS = 8'h04;
	localparam logic [7:0] HSP_OFS_MASK   = 8'h08;
	localparam logic [7:0] HSP_OFS_STATE  = 8'h0c;
	localparam logic [7:0] HSP_OFS_FREQ   = 8'h10;
	// control register fields
	localparam int HSP_CTRL_SUSP_SEL  = 0;
	localparam int HSP_CTRL_PWR       = 1;
	localparam int HSP_CTRL_CONNECT_N = 2;
	localparam int HSP_CTRL_CONFIGURED = 3;
	localparam int HSP_CTRL_SUSPENDED = 4;
	localparam logic [4:0] HSP_CTRL_RST = 5'h04;
	// event / status / mask fields
	localparam int HSP_EVT_NUM       = 3;
	localparam int HSP_EVT_FAULT     = 0;
	localparam int HSP_EVT_CONN_RISE = 1;
	localparam int HSP_EVT_COMM      = 2;
	localparam logic [2:0] HSP_MASK_RST = 3'h0;
	// state register fields
	localparam int HSP_ST_FAULT   = 0;
	localparam int HSP_ST_CONNECT = 1;
	localparam int HSP_ST_STAGE   = 2;
	localparam int HSP_ST_REFSEL  = 4;
	localparam int HSP_ST_SECOND  = 6;
	localparam int HSP_ST_STANDBY = 7;
	// init stage length
	localparam int HSP_CLK_MHZ  = 40;
	localparam int HSP_INIT_NS  = 1000;
	localparam int HSP_INIT_CYC = (HSP_INIT_NS * HSP_CLK_MHZ + 999) / 1000;
	// reference frequencies in kHz, indexed by select code
	localparam logic [15:0] HSP_FREQ_PRI [4] = '{16'h9600, 16'h6590, 16'h4b00, 16'h2ee0};
	localparam logic [15:0] HSP_FREQ_SEC [4] = '{16'h5dc0, 16'h6978, 16'h61a8, 16'hc350};
	typedef enum logic [1:0] {HSP_STG_INIT, HSP_STG_CONFIG, HSP_STG_COMM} hsp_stage_t;
endpackage
`default_nettype wire

// ===== hw/hsp_evt_if.sv
// interface between the core and the latched interrupt status block
`default_nettype none
interface hsp_evt_if #(parameter int N = 3);
	logic [N-1:0] evt;
	logic         clr_stb;
	logic [N-1:0] clr_data;
	logic [N-1:0] mask_wdata;
	logic         mask_stb;
	logic [N-1:0] status;
	logic [N-1:0] mask;
	logic         pend;
	modport core (output evt, clr_stb, clr_data, mask_wdata, mask_stb,
		input status, mask, pend);
	modport irq (input evt, clr_stb, clr_data, mask_wdata, mask_stb,
		output status, mask, pend);
endinterface
`default_nettype wire

// ===== hw/hsp_sync.sv
// two flip-flop level synchroniser
`default_nettype none
module hsp_sync #(
	parameter int W = 2
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output var  logic [W-1:0] q
);
	logic [W-1:0] meta_r;

	// first stage read only by the second
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= '0;
			q      <= '0;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule // hsp_sync
`default_nettype wire

// ===== hw/hsp_irq.sv
// sticky interrupt status with write-one-to-clear and mask
`default_nettype none
module hsp_irq
	import hsp_pkg::*;
#(
	parameter int N = 3
) (
	input  wire logic pclk,
	input  wire logic presetn,
	hsp_evt_if.irq    e
);
	logic [N-1:0] status_r;
	logic [N-1:0] status_nxt;
	logic [N-1:0] mask_r;
	logic [N-1:0] mask_nxt;

	always_comb begin
		// a new event wins over a clear in the same cycle
		status_nxt = status_r;
		if (e.clr_stb) begin
			status_nxt = status_r & ~e.clr_data;
		end
		status_nxt = status_nxt | e.evt;
		mask_nxt = e.mask_stb ? e.mask_wdata : mask_r;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_r <= '0;
			mask_r   <= HSP_MASK_RST;
		end else begin
			status_r <= status_nxt;
			mask_r   <= mask_nxt;
		end
	end

	assign e.status = status_r;
	assign e.mask   = mask_r;
	assign e.pend   = |(status_r & mask_r);
endmodule // hsp_irq
`default_nettype wire

// ===== test/hsp_top_sva.sv
// port assertions for the sideband pin control block
`default_nettype none
module hsp_chk
	import hsp_pkg::*;
#(
	parameter int INIT_CYC = 4
) (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        irq,
	input wire logic        int_pin_out,
	input wire logic        int_pin_oe,
	input wire logic        port_power_enable,
	input wire logic [15:0] ref_freq_khz,
	input wire logic        standby
);
	logic       wr_done;
	logic       ctrl_wr;
	logic [7:0] cnt_r;
	logic [7:0] cnt_nxt;
	assign wr_done = psel && penable && pready && pwrite;
	assign ctrl_wr = wr_done && paddr == HSP_OFS_CTRL;
	// saturating cycle count since reset release
	always_comb cnt_nxt = (cnt_r == 8'hff) ? cnt_r : cnt_r + 8'h01;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) cnt_r <= 8'h00;
		else cnt_r <= cnt_nxt;
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_req;
		psel && !penable ##1 psel && penable;
	endsequence
	////////////////////////////////////////////////////////////////////////////////
	AST_STANDBY: assert property ($past(presetn) |-> !standby)
		else $error("standby high after reset release");
	AST_STBY_PINS: assert property (standby |-> !int_pin_oe && !port_power_enable)
		else $error("pins active while standby shown");
	AST_APB_WAIT: assert property (s_req |-> ##1 pready)
		else $error("pready not in second access cycle");
	AST_APB_ERR: assert property (psel && penable && pready |->
		pslverr == (paddr > HSP_OFS_FREQ || paddr[1:0] != 2'h0))
		else $error("pslverr wrong for address");
	// control lands at the pready edge, the pin flop one edge later
	AST_PWR_SET: assert property (ctrl_wr |->
		##2 port_power_enable == $past(pwdata[1], 2))
		else $error("port power does not follow control write");
	AST_PWR_HOLD: assert property (!ctrl_wr |-> ##2 $stable(port_power_enable))
		else $error("port power moved without a write");
	AST_OD_LOW: assert property (int_pin_out == 1'b0)
		else $error("open drain pin driven high");
	AST_IRQ_CLR: assert property ($fell(irq) |-> $past(wr_done, 2))
		else $error("irq released without host write");
	AST_OE_CLR: assert property ($fell(int_pin_oe) |-> $past(wr_done, 2))
		else $error("interrupt pin released without host write");
	AST_OE_INIT: assert property (cnt_r < INIT_CYC |-> !int_pin_oe)
		else $error("interrupt pin pulled during init");
	AST_FREQ: assert property (ref_freq_khz != 16'h0000 |=> $stable(ref_freq_khz))
		else $error("reference frequency changed after capture");
endmodule // hsp_chk
bind hsp_top hsp_chk #(.INIT_CYC(INIT_CYC)) u_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .irq(irq),
	.int_pin_out(int_pin_out), .int_pin_oe(int_pin_oe),
	.port_power_enable(port_power_enable), .ref_freq_khz(ref_freq_khz), .standby(standby));
`default_nettype wire

// ===== test/hsp_host_model.sv
// host and power switch model at the far side of the sideband pins
`default_nettype none
module hsp_host_model (
	input  wire logic int_pin_oe,
	input  wire logic strap_low,
	input  wire logic fault_inj,
	input  wire logic port_power_enable,
	output var  logic int_wire,
	output var  logic overcurrent_sense_low,
	output var  logic powered
);
	timeunit 1ns;
	timeprecision 1ps;
	// pull-up unless hub or host strap sinks the wire
	assign int_wire = !(int_pin_oe || strap_low);
	assign powered = port_power_enable;
	// monitor reports regardless of power: no kinder than a real one
	assign overcurrent_sense_low = !fault_inj;
endmodule // hsp_host_model
`default_nettype wire

// ===== test/hsp_top_tb.sv
// self-checking bench for the sideband pin control block
`default_nettype none
module hsp_top_tb;
	import hsp_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int INIT = 4;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic        hub_connect = 1'b0, strap_low = 1'b0, fault_inj = 1'b0;
	logic [1:0]  ref_sel = 2'h2;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [15:0] ref_freq_khz;
	logic        pready, pslverr, irq, int_pin_out, int_pin_oe, port_power_enable, standby;
	logic        int_wire, ocs_low, powered;
	int          miscompares = 0;
	int          n_compared = 0;
	hsp_top #(.INIT_CYC(INIT)) DUT (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.irq(irq), .hub_connect(hub_connect), .overcurrent_sense_low(ocs_low),
		.ref_sel(ref_sel), .int_pin_in(int_wire), .int_pin_out(int_pin_out),
		.int_pin_oe(int_pin_oe), .port_power_enable(port_power_enable),
		.ref_freq_khz(ref_freq_khz), .standby(standby));
	hsp_host_model HOST (.int_pin_oe(int_pin_oe), .strap_low(strap_low), .fault_inj(fault_inj),
		.port_power_enable(port_power_enable), .int_wire(int_wire),
		.overcurrent_sense_low(ocs_low), .powered(powered));
	initial begin
		forever #12.5 pclk = ~pclk;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic end_of_test;
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	// master waits for pready, never assumes the wait state count
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1);
		// the wait is open; only the watchdog ends it, latency judged here
		chk("pready wait", 32'h2, n);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask
	task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0, r, e);
		chk(what, exp, r);
	endtask
	task automatic wait_irq(input logic exp);
		int n;
		n = 0;
		while (irq !== exp && n < 20) begin
			@(posedge pclk);
			n++;
		end
		chk("irq", {31'h0, exp}, {31'h0, irq});
		chk("int wire", {31'h0, !exp}, {31'h0, int_wire});
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic do_reset(input logic s, input logic [1:0] sel);
		@(posedge pclk);
		presetn <= 1'b0;
		strap_low <= s;
		ref_sel <= sel;
		hub_connect <= 1'b0;
		repeat (2) @(posedge pclk);
		chk("standby", 32'h1, {31'h0, standby});
		chk("freq in reset", 32'h0, {16'h0, ref_freq_khz});
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		repeat (INIT + 8) @(posedge pclk);
		// host strap turns into a listener after startup
		strap_low <= 1'b0;
		$display("reset done");
	endtask
	task automatic t_config;
		logic [31:0] r;
		logic        e;
		chk("freq primary", 32'h4b00, {16'h0, ref_freq_khz});
		rd("ctrl", HSP_OFS_CTRL, 32'h04);
		rd("mask", HSP_OFS_MASK, 32'h0);
		apb(1'b0, 8'h40, 32'h0, r, e);
		chk("unmapped err", 32'h1, {31'h0, e});
		rd("state config", HSP_OFS_STATE, 32'h24);
		wr(HSP_OFS_CTRL, 32'h0);
		rd("state comm", HSP_OFS_STATE, 32'h28);
		$display("config test done");
	endtask
	task automatic t_fault;
		wr(HSP_OFS_STATUS, 32'h7);
		wr(HSP_OFS_CTRL, 32'h06);
		repeat (2) @(posedge pclk);
		chk("power on", 32'h1, {31'h0, powered});
		fault_inj <= 1'b1;
		repeat (8) @(posedge pclk);
		wait_irq(1'b0);
		rd("status fault", HSP_OFS_STATUS, 32'h1);
		wr(HSP_OFS_MASK, 32'h1);
		wait_irq(1'b1);
		fault_inj <= 1'b0;
		repeat (8) @(posedge pclk);
		wait_irq(1'b1);
		wr(HSP_OFS_STATUS, 32'h1);
		wait_irq(1'b0);
		fault_inj <= 1'b1;
		wait_irq(1'b1);
		wr(HSP_OFS_MASK, 32'h0);
		wait_irq(1'b0);
		fault_inj <= 1'b0;
		wr(HSP_OFS_CTRL, 32'h04);
		repeat (2) @(posedge pclk);
		chk("power off", 32'h0, {31'h0, powered});
		$display("fault test done");
	endtask
	task automatic t_susp;
		logic [31:0] cv [3];
		cv = '{32'h01, 32'h09, 32'h19};
		for (int i = 0; i < 3; i++) begin
			wr(HSP_OFS_CTRL, cv[i]);
			repeat (3) @(posedge pclk);
			chk("suspend level", {31'h0, i == 1}, {31'h0, int_wire});
		end
		$display("suspend test done");
	endtask
	task automatic t_rise;
		chk("freq secondary", 32'hc350, {16'h0, ref_freq_khz});
		rd("state second", HSP_OFS_STATE, 32'h74);
		hub_connect <= 1'b1;
		repeat (8) @(posedge pclk);
		rd("state rise", HSP_OFS_STATE, 32'h7a);
		rd("status rise", HSP_OFS_STATUS, 32'h6);
		$display("connect test done");
	endtask
	// connect pulse seen only during init must still lead to communication
	task automatic t_pulse;
		@(posedge pclk);
		presetn <= 1'b0;
		hub_connect <= 1'b0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		hub_connect <= 1'b1;
		@(posedge pclk);
		hub_connect <= 1'b0;
		repeat (INIT + 8) @(posedge pclk);
		chk("freq pulse", 32'h2ee0, {16'h0, ref_freq_khz});
		rd("state pulse", HSP_OFS_STATE, 32'h38);
		rd("status pulse", HSP_OFS_STATUS, 32'h6);
		$display("pulse test done");
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		do_reset(1'b0, 2'h2);
		t_config;
		t_fault;
		t_susp;
		do_reset(1'b1, 2'h3);
		t_rise;
		t_pulse;
		end_of_test;
	end
	// whole run is well under a thousand cycles
	initial begin
		repeat (5000) @(posedge pclk);
		miscompares++;
		end_of_test;
	end
endmodule // hsp_top_tb
`default_nettype wire
